/* File: dma_cfg.svh */
// Register offsets, field positions and encodings of the DMA channel.
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

`define OFS_SOURCE_ADDRESS      8'h00
`define OFS_DESTINATION_ADDRESS 8'h04
`define OFS_BYTE_COUNT          8'h08
`define OFS_CHANNEL_CONTROL     8'h0c
`define OFS_CHANNEL_STATUS      8'h10
`define OFS_IRQ_STATUS          8'h14
`define OFS_IRQ_CLEAR           8'h18
`define OFS_IRQ_ENABLE          8'h1c

`define BYTE_COUNT_W            24
`define CTRL_RESET              32'h0000_0000

`define SECOND_LINK_LSB         0
`define FIRST_LINK_LSB          2
`define LINK_COND_LSB           4
`define START_BIT               16
`define PERIPH_EN_BIT           17
`define CYCLE_STEAL_BIT         18
`define SRC_INC_BIT             19
`define DST_INC_BIT             20
`define SRC_SIZE_LSB            21
`define DST_SIZE_LSB            23
`define AUTO_ALIGN_BIT          25

`define LINK_NONE               2'b00
`define LINK_EACH_THEN_SECOND   2'b01
`define LINK_EACH               2'b10
`define LINK_AT_END             2'b11

`define SIZE_32                 2'b00
`define SIZE_8                  2'b01
`define SIZE_16                 2'b10

`define STAT_DONE_BIT           0
`define STAT_BUSY_BIT           1
`define STAT_CFG_ERR_BIT        2

`define IRQ_DONE_BIT            0
`define IRQ_CFG_ERR_BIT         1
`define IRQ_W                   2

`endif

/* File: dma_pkg.sv */
// Types shared by the DMA channel files.
package dma_pkg;
    typedef enum logic [2:0] {
        IDLE,
        CHECK,
        READ,
        WRITE,
        UPDATE
    } chan_state_e;

    typedef logic [1:0] chan_sel_t;
endpackage

/* File: irq_status.sv */
// Sticky interrupt status with enable mask and write-one-to-clear.
`timescale 1ns/1ps
module irq_status #(
    parameter int WIDTH = 2
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] events,
    input  wire logic             clearWr,
    input  wire logic             enableWr,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] status,
    output logic      [WIDTH-1:0] enable,
    output logic                  irq
);
    logic [WIDTH-1:0] statusD;

    // A new event wins over a clear landing in the same cycle.
    assign statusD = (status & ~(clearWr ? wrData : '0)) | events;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            status <= '0;
            enable <= '0;
            irq    <= 1'b0;
        end else begin
            status <= statusD;
            if (enableWr) begin
                enable <= wrData;
            end
            irq <= |(statusD & (enableWr ? wrData : enable));
        end
    end
endmodule

/* File: dma_channel.sv */
// One DMA channel: request, transfer, configuration check and linking.
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dma_cfg.svh"

module dma_channel
    import dma_pkg::*;
#(
    parameter chan_sel_t CHANNEL_ID = 2'd0
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        periphReq,
    input  wire logic        linkReqIn,
    output logic      [3:0]  linkReqOut,
    output logic             mValid,
    output logic             mWrite,
    output logic      [31:0] mAddr,
    output logic      [1:0]  mSize,
    output logic      [31:0] mWdata,
    input  wire logic        mReady,
    input  wire logic [31:0] mRdata,
    output logic             irq
);
    function automatic logic [2:0] sizeBytes(input logic [1:0] code);
        return (code == `SIZE_8) ? 3'd1 : (code == `SIZE_16) ? 3'd2 : (code == `SIZE_32) ? 3'd4 : 3'd0;
    endfunction

    function automatic logic misaligned(input logic [31:0] addr, input logic [2:0] bytes);
        logic [1:0] lowMask;
        lowMask = bytes[1:0] - 2'd1;
        return (addr[1:0] & lowMask) != 2'b00;
    endfunction

    function automatic logic [3:0] oneHot(input chan_sel_t sel);
        return 4'b0001 << sel;
    endfunction

    chan_state_e                    stateQ;
    chan_state_e                    stateD;
    logic [31:0]                    srcQ;
    logic [31:0]                    dstQ;
    logic [`BYTE_COUNT_W-1:0]       bcrQ;
    logic [31:0]                    ctrlQ;
    logic                           startQ;
    logic                           doneQ;
    logic                           cfgErrQ;
    logic [31:0]                    holdQ;
    logic [2:0]                     offQ;
    logic                           wrPendQ;
    logic [7:0]                     wrAddrQ;
    logic [`IRQ_W-1:0]              irqEvents;
    logic [`IRQ_W-1:0]              irqStat;
    logic [`IRQ_W-1:0]              irqEn;

    // Control field decode.
    wire chan_sel_t  firstLink  = ctrlQ[`FIRST_LINK_LSB +: 2];
    wire chan_sel_t  secondLink = ctrlQ[`SECOND_LINK_LSB +: 2];
    wire logic [1:0] linkCond   = ctrlQ[`LINK_COND_LSB +: 2];
    wire logic       cycleSteal = ctrlQ[`CYCLE_STEAL_BIT];
    wire logic       perEn      = ctrlQ[`PERIPH_EN_BIT];
    wire logic       srcInc     = ctrlQ[`SRC_INC_BIT];
    wire logic       dstInc     = ctrlQ[`DST_INC_BIT];
    wire logic       autoAlign  = ctrlQ[`AUTO_ALIGN_BIT];
    wire logic [2:0] srcBytes   = sizeBytes(ctrlQ[`SRC_SIZE_LSB +: 2]);
    wire logic [2:0] dstBytes   = sizeBytes(ctrlQ[`DST_SIZE_LSB +: 2]);
    wire logic [2:0] xferBytes  = (srcBytes > dstBytes) ? srcBytes : dstBytes;

    // Register bus decode; the slave never inserts wait states.
    wire logic       addrPhase = hsel & htrans[1] & hready;
    wire logic       regWr     = wrPendQ;
    wire logic       wrSrc     = regWr && (wrAddrQ == `OFS_SOURCE_ADDRESS);
    wire logic       wrDst     = regWr && (wrAddrQ == `OFS_DESTINATION_ADDRESS);
    wire logic       wrBcr     = regWr && (wrAddrQ == `OFS_BYTE_COUNT);
    wire logic       wrCtrl    = regWr && (wrAddrQ == `OFS_CHANNEL_CONTROL);
    wire logic       wrStat    = regWr && (wrAddrQ == `OFS_CHANNEL_STATUS);
    wire logic       wrIrqClr  = regWr && (wrAddrQ == `OFS_IRQ_CLEAR);
    wire logic       wrIrqEn   = regWr && (wrAddrQ == `OFS_IRQ_ENABLE);
    wire logic [31:0] statusWord = {29'd0, cfgErrQ, stateQ != IDLE, doneQ};
    wire logic [31:0] readWord =
        (haddr[7:0] == `OFS_SOURCE_ADDRESS)      ? srcQ :
        (haddr[7:0] == `OFS_DESTINATION_ADDRESS) ? dstQ :
        (haddr[7:0] == `OFS_BYTE_COUNT)          ? {8'd0, bcrQ} :
        (haddr[7:0] == `OFS_CHANNEL_CONTROL)     ? {ctrlQ[31:`START_BIT+1], startQ, ctrlQ[`START_BIT-1:0]} :
        (haddr[7:0] == `OFS_CHANNEL_STATUS)      ? statusWord :
        (haddr[7:0] == `OFS_IRQ_STATUS)          ? {30'd0, irqStat} :
        (haddr[7:0] == `OFS_IRQ_ENABLE)          ? {30'd0, irqEn} : 32'd0;

    // Requests: the peripheral line only counts while enabled.
    wire logic reqNow = startQ | (perEn & periphReq);

    // Configuration check before every transfer. Under auto-align the aligned side is not checked.
    wire logic srcAlignSide = srcBytes >= dstBytes;
    wire logic checkSrc     = !(autoAlign && srcAlignSide);
    wire logic checkDst     = !(autoAlign && !srcAlignSide);
    wire logic sizeBad      = (srcBytes == 3'd0) || (dstBytes == 3'd0);
    wire logic selfLink     = (linkCond != `LINK_NONE) && (firstLink == CHANNEL_ID || secondLink == CHANNEL_ID);
    wire logic cfgErr       = sizeBad || selfLink
                            || (checkSrc && misaligned(srcQ, srcBytes))
                            || (checkDst && misaligned(dstQ, dstBytes));

    // Beat sequencing inside one transfer.
    wire logic       beatDone  = mValid && mReady;
    wire logic [2:0] beatBytes = (stateQ == READ) ? srcBytes : dstBytes;
    wire logic [2:0] offNext   = offQ + beatBytes;
    wire logic       lastBeat  = offNext >= xferBytes;
    wire logic [31:0] byteMask = (beatBytes == 3'd1) ? 32'h0000_00ff : (beatBytes == 3'd2) ? 32'h0000_ffff : 32'hffff_ffff;
    wire logic [31:0] rdMerged = holdQ | ((mRdata & byteMask) << {offQ, 3'b000});

    // Byte count update; a short remainder clamps to zero.
    wire logic [`BYTE_COUNT_W-1:0] xferWide = {{(`BYTE_COUNT_W-3){1'b0}}, xferBytes};
    wire logic [`BYTE_COUNT_W-1:0] bcrNext  = (bcrQ > xferWide) ? bcrQ - xferWide : '0;
    wire logic                     lastXfer = bcrNext == '0;

    // Link selection at the end of each transfer.
    wire logic linkFirst  = ((linkCond == `LINK_EACH_THEN_SECOND) && cycleSteal && !lastXfer)
                          || ((linkCond == `LINK_EACH) && cycleSteal)
                          || ((linkCond == `LINK_AT_END) && lastXfer);
    wire logic linkSecond = (linkCond == `LINK_EACH_THEN_SECOND) && lastXfer;
    wire logic [3:0] linkVec = (stateQ != UPDATE) ? 4'b0000 :
                               linkFirst ? oneHot(firstLink) : linkSecond ? oneHot(secondLink) : 4'b0000;

    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            IDLE:   if (reqNow) stateD = CHECK;
            CHECK:  stateD = cfgErr ? IDLE : READ;
            READ:   if (beatDone && lastBeat) stateD = WRITE;
            WRITE:  if (beatDone && lastBeat) stateD = UPDATE;
            UPDATE: stateD = (lastXfer || cycleSteal) ? IDLE : CHECK;
        endcase
    end

    assign irqEvents = {(stateQ == CHECK) && cfgErr, (stateQ == UPDATE) && lastXfer};

    irq_status #(
        .WIDTH(`IRQ_W)
    ) u_irq (
        .clock   (clock),
        .reset   (reset),
        .events  (irqEvents),
        .clearWr (wrIrqClr),
        .enableWr(wrIrqEn),
        .wrData  (hwdata[`IRQ_W-1:0]),
        .status  (irqStat),
        .enable  (irqEn),
        .irq     (irq)
    );

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hreadyout <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
            wrPendQ   <= 1'b0;
            wrAddrQ   <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPendQ   <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddrQ <= haddr[7:0];
                hrdata  <= hwrite ? 32'h0000_0000 : readWord;
            end
        end
    end

    // A software write to an address register takes priority over the hardware increment.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            srcQ <= 32'h0000_0000;
            dstQ <= 32'h0000_0000;
            bcrQ <= '0;
        end else begin
            if (wrSrc) begin
                srcQ <= hwdata;
            end else if (stateQ == UPDATE && srcInc) begin
                srcQ <= srcQ + {29'd0, xferBytes};
            end
            if (wrDst) begin
                dstQ <= hwdata;
            end else if (stateQ == UPDATE && dstInc) begin
                dstQ <= dstQ + {29'd0, xferBytes};
            end
            if (wrBcr) begin
                bcrQ <= hwdata[`BYTE_COUNT_W-1:0];
            end else if (stateQ == UPDATE) begin
                bcrQ <= bcrNext;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrlQ <= `CTRL_RESET;
        end else if (wrCtrl) begin
            ctrlQ <= hwdata;
        end
    end

    // A link arriving while the start bit is being consumed is kept for the next activation.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            startQ <= 1'b0;
        end else if (linkReqIn || (wrCtrl && hwdata[`START_BIT])) begin
            startQ <= 1'b1;
        end else if (stateQ == IDLE && reqNow) begin
            startQ <= 1'b0;
        end
    end

    // Done and configuration error are set by hardware, cleared by writing one to done; set wins.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            doneQ   <= 1'b0;
            cfgErrQ <= 1'b0;
        end else begin
            doneQ   <= ((stateQ == UPDATE) && lastXfer) || (doneQ && !(wrStat && hwdata[`STAT_DONE_BIT]));
            cfgErrQ <= ((stateQ == CHECK) && cfgErr) || (cfgErrQ && !(wrStat && hwdata[`STAT_DONE_BIT]));
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stateQ     <= IDLE;
            linkReqOut <= 4'b0000;
        end else begin
            stateQ     <= stateD;
            linkReqOut <= linkVec;
        end
    end

    // Each beat holds its request until the crossbar accepts it, then idles one cycle.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mValid <= 1'b0;
            mWrite <= 1'b0;
            mAddr  <= 32'h0000_0000;
            mSize  <= `SIZE_32;
            mWdata <= 32'h0000_0000;
            holdQ  <= 32'h0000_0000;
            offQ   <= 3'd0;
        end else if (beatDone) begin
            mValid <= 1'b0;
            offQ   <= lastBeat ? 3'd0 : offNext;
            if (stateQ == READ) begin
                holdQ <= rdMerged;
            end
        end else if ((stateQ == READ || stateQ == WRITE) && !mValid) begin
            mValid <= 1'b1;
            mWrite <= stateQ == WRITE;
            mAddr  <= ((stateQ == READ) ? srcQ : dstQ) + {29'd0, offQ};
            mSize  <= ctrlQ[((stateQ == READ) ? `SRC_SIZE_LSB : `DST_SIZE_LSB) +: 2];
            mWdata <= (holdQ >> {offQ, 3'b000}) & byteMask;
        end else if (stateQ == CHECK) begin
            holdQ <= 32'h0000_0000;
            offQ  <= 3'd0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_update_cs;
        stateQ == UPDATE && cycleSteal;
    endsequence

    property p_start_clears;
        (stateQ == IDLE && reqNow && !linkReqIn && !wrCtrl) |=> (!startQ && stateQ == CHECK);
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start bit not cleared on activation");

    property p_cfg_err_stop;
        (stateQ == CHECK && cfgErr) |=> (stateQ == IDLE && cfgErrQ && irqStat[`IRQ_CFG_ERR_BIT]) ##1 !mValid;
    endproperty
    a_cfg_err_stop: assert property (p_cfg_err_stop) else $error("configuration error did not stop transfer");

    property p_self_link;
        (stateQ == CHECK && selfLink) |=> (cfgErrQ && stateQ == IDLE) ##1 linkReqOut == 4'b0000;
    endproperty
    a_self_link: assert property (p_self_link) else $error("self link not flagged");

    property p_link_each;
        (s_update_cs and (linkCond == `LINK_EACH)) |=> linkReqOut == oneHot($past(firstLink));
    endproperty
    a_link_each: assert property (p_link_each) else $error("link code 10 missed first channel");

    property p_link_end;
        (stateQ == UPDATE && linkCond == `LINK_AT_END) |=> linkReqOut == ($past(lastXfer) ? oneHot($past(firstLink)) : 4'b0000);
    endproperty
    a_link_end: assert property (p_link_end) else $error("link code 11 wrong");

    property p_link_second;
        (s_update_cs and (linkCond == `LINK_EACH_THEN_SECOND) and lastXfer) |=> linkReqOut == oneHot($past(secondLink));
    endproperty
    a_link_second: assert property (p_link_second) else $error("last transfer did not link second channel");

    property p_no_link_cont;
        (stateQ == UPDATE && !cycleSteal && (linkCond == `LINK_EACH || (linkCond == `LINK_EACH_THEN_SECOND && !lastXfer)))
            |=> linkReqOut == 4'b0000;
    endproperty
    a_no_link_cont: assert property (p_no_link_cont) else $error("continuous mode linked first channel");

    property p_periph_ignored;
        (stateQ == IDLE && !startQ && !perEn) |=> stateQ == IDLE;
    endproperty
    a_periph_ignored: assert property (p_periph_ignored) else $error("disabled peripheral request started channel");

    property p_cs_one;
        (s_update_cs and !lastXfer) |=> stateQ == IDLE;
    endproperty
    a_cs_one: assert property (p_cs_one) else $error("cycle steal did more than one transfer");

    property p_cont_runs;
        (stateQ == UPDATE && !cycleSteal && !lastXfer) |=> stateQ == CHECK;
    endproperty
    a_cont_runs: assert property (p_cont_runs) else $error("continuous mode stopped early");

    property p_src_hold;
        (stateQ == UPDATE && !srcInc && !wrSrc) |=> srcQ == $past(srcQ);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source address moved without increment");

    property p_read_then_write;
        (stateQ == READ && beatDone && lastBeat) |=> (stateQ == WRITE && !mValid) ##1 (mValid && mWrite);
    endproperty
    a_read_then_write: assert property (p_read_then_write) else $error("write did not follow read");
endmodule

/* File: bus_partner.sv */
// Behavioural system bus model: a word memory with optional wait states.
`timescale 1ns/1ps
module bus_partner (
    input  wire logic        clock,
    input  wire logic        slow,
    input  wire logic        mValid,
    input  wire logic        mWrite,
    input  wire logic [31:0] mAddr,
    input  wire logic [31:0] mWdata,
    output logic             mReady,
    output logic      [31:0] mRdata
);
    logic [31:0] mem [64];
    logic [1:0]  waitCount_q;

    // Every beat is served on its own, so a fresh wait can hit each one.
    // A plain process, so that the bench may preload and clear words of the memory directly.
    always @(posedge clock) begin
        waitCount_q <= (mValid && !mReady) ? waitCount_q + 2'd1 : 2'd0;
        if (mValid && mReady && mWrite) begin
            mem[mAddr[7:2]] <= mWdata;
        end
    end

    assign mReady = mValid && (!slow || waitCount_q == 2'd2);
    // Outside a read beat the lines carry garbage, so stale data cannot pass.
    assign mRdata = (mValid && !mWrite) ? mem[mAddr[7:2]] : ~mem[mAddr[7:2]];
endmodule

/* File: dma_channel_tb.sv */
// Self-checking testbench for one DMA channel.
`timescale 1ns/1ps
`include "dma_cfg.svh"
module dma_channel_tb;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] sar;
        logic [23:0] cnt;
        logic [1:0]  trig;
        logic [3:0]  expLink;
        logic [23:0] expCnt;
        logic [2:0]  expStat;
    } row_s;

    logic        clock;
    logic        reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        periphReq;
    logic        linkReqIn;
    logic [3:0]  linkReqOut;
    logic        mValid;
    logic        mWrite;
    logic [31:0] mAddr;
    logic [1:0]  mSize;
    logic [31:0] mWdata;
    logic        mReady;
    logic [31:0] mRdata;
    logic        irq;
    logic        slow;
    logic [3:0]  linkSeen;
    logic        linkClr;
    logic [1:0]  sizeOr;
    logic [31:0] q;
    row_s        rows [14];
    int          mismatches;
    int          tests_run;
    int          cycles;

    dma_channel u_dma_channel (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .periphReq(periphReq), .linkReqIn(linkReqIn), .linkReqOut(linkReqOut),
        .mValid(mValid), .mWrite(mWrite), .mAddr(mAddr), .mSize(mSize), .mWdata(mWdata), .mReady(mReady),
        .mRdata(mRdata), .irq(irq));

    bus_partner u_bus_partner (.clock(clock), .slow(slow), .mValid(mValid), .mWrite(mWrite), .mAddr(mAddr),
        .mWdata(mWdata), .mReady(mReady), .mRdata(mRdata));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        // Clearing goes through a flag, so apart from the initial zeroing only this process writes the collected links.
        linkSeen <= linkClr ? 4'h0 : (linkSeen | linkReqOut);
        sizeOr <= sizeOr | (mValid ? mSize : 2'b00);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Called just after a rising edge; returns just after the edge ending the data phase.
    task automatic busOp(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        busOp(1'b1, a, d, unused);
    endtask

    function automatic logic [31:0] mk(input logic cs, input logic peripheral_request_enable, input logic [1:0] cond,
                                       input logic [1:0] l1, input logic [1:0] l2);
        return (32'(cs) << `CYCLE_STEAL_BIT) | (32'(peripheral_request_enable) << `PERIPH_EN_BIT) | (32'h1 << `SRC_INC_BIT)
             | (32'h1 << `DST_INC_BIT) | (32'(cond) << `LINK_COND_LSB) | (32'(l1) << `FIRST_LINK_LSB) | 32'(l2);
    endfunction

    task automatic runRow(input row_s r, input int i);
        slow <= i[0];
        u_bus_partner.mem[32] = 32'h0;
        linkClr <= 1'b1;
        wr(`OFS_SOURCE_ADDRESS, r.sar);
        linkClr <= 1'b0;
        wr(`OFS_DESTINATION_ADDRESS, 32'h80);
        wr(`OFS_BYTE_COUNT, 32'(r.cnt));
        wr(`OFS_CHANNEL_STATUS, 32'h1);
        wr(`OFS_CHANNEL_CONTROL, r.ctrl | ((r.trig == 2'd0) ? (32'h1 << `START_BIT) : 32'h0));
        periphReq <= (r.trig == 2'd1);
        linkReqIn <= (r.trig == 2'd2);
        @(posedge clock);
        periphReq <= 1'b0;
        linkReqIn <= 1'b0;
        busOp(1'b0, `OFS_CHANNEL_STATUS, 32'h0, q);
        busOp(1'b0, `OFS_CHANNEL_STATUS, 32'h0, q);
        while (q[`STAT_BUSY_BIT] !== 1'b0) begin
            busOp(1'b0, `OFS_CHANNEL_STATUS, 32'h0, q);
        end
        check("status", {29'h0, q[2:0]}, {29'h0, r.expStat});
        busOp(1'b0, `OFS_BYTE_COUNT, 32'h0, q);
        check("byte_count", q, 32'(r.expCnt));
        busOp(1'b0, `OFS_SOURCE_ADDRESS, 32'h0, q);
        check("source_address", q, r.sar + 32'(r.cnt - r.expCnt));
        busOp(1'b0, `OFS_CHANNEL_CONTROL, 32'h0, q);
        check("start", {31'h0, q[`START_BIT]}, 32'h0);
        check("link", {28'h0, linkSeen}, {28'h0, r.expLink});
        check("dest_word", u_bus_partner.mem[32], (r.cnt != r.expCnt) ? 32'hc3a5_0008 : 32'h0);
    endtask

    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, periphReq, linkReqIn, slow} = '0;
        linkSeen = 4'h0;
        linkClr = 1'b0;
        sizeOr = 2'b00;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        reset = 1'b1;
        for (int k = 0; k < 64; k++) u_bus_partner.mem[k] = 32'hc3a5_0000 + 32'(k);
        rows[0]  = '{mk(1, 0, 2'b10, 2'd2, 2'd3), 32'h20, 24'd8, 2'd0, 4'b0100, 24'd4, 3'b000};
        rows[1]  = '{mk(1, 0, 2'b11, 2'd1, 2'd3), 32'h20, 24'd8, 2'd0, 4'b0000, 24'd4, 3'b000};
        rows[2]  = '{mk(1, 0, 2'b11, 2'd1, 2'd3), 32'h20, 24'd4, 2'd0, 4'b0010, 24'd0, 3'b001};
        rows[3]  = '{mk(1, 0, 2'b01, 2'd3, 2'd2), 32'h20, 24'd8, 2'd0, 4'b1000, 24'd4, 3'b000};
        rows[4]  = '{mk(1, 0, 2'b01, 2'd3, 2'd2), 32'h20, 24'd4, 2'd0, 4'b0100, 24'd0, 3'b001};
        rows[5]  = '{mk(0, 0, 2'b10, 2'd2, 2'd3), 32'h20, 24'd8, 2'd0, 4'b0000, 24'd0, 3'b001};
        rows[6]  = '{mk(1, 0, 2'b10, 2'd0, 2'd3), 32'h20, 24'd8, 2'd0, 4'b0000, 24'd8, 3'b100};
        rows[7]  = '{mk(1, 0, 2'b00, 2'd2, 2'd0), 32'h20, 24'd8, 2'd0, 4'b0000, 24'd4, 3'b000};
        rows[8]  = '{mk(1, 1, 2'b10, 2'd2, 2'd3), 32'h20, 24'd8, 2'd1, 4'b0100, 24'd4, 3'b000};
        rows[9]  = '{mk(1, 0, 2'b10, 2'd2, 2'd3), 32'h20, 24'd8, 2'd1, 4'b0000, 24'd8, 3'b000};
        rows[10] = '{mk(1, 0, 2'b10, 2'd2, 2'd3), 32'h20, 24'd8, 2'd2, 4'b0100, 24'd4, 3'b000};
        rows[11] = '{mk(1, 0, 2'b10, 2'd2, 2'd3), 32'h22, 24'd8, 2'd0, 4'b0000, 24'd8, 3'b100};
        rows[12] = '{mk(1, 0, 2'b10, 2'd2, 2'd3) | (32'h1 << `AUTO_ALIGN_BIT),
                     32'h22, 24'd8, 2'd0, 4'b0100, 24'd4, 3'b000};
        rows[13] = '{mk(1, 0, 2'b10, 2'd2, 2'd3) | (32'h3 << `SRC_SIZE_LSB),
                     32'h20, 24'd8, 2'd0, 4'b0000, 24'd8, 3'b100};
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        busOp(1'b0, `OFS_CHANNEL_CONTROL, 32'h0, q);
        check("control_reset", q, `CTRL_RESET);
        wr(8'h40, 32'hffff_ffff);
        busOp(1'b0, 8'h40, 32'h0, q);
        check("unmapped", q, 32'h0);
        check("irq_reset", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 14; i++) runRow(rows[i], i);
        check("beat_size", {30'h0, sizeOr}, 32'h0);
        check("irq_masked", {31'h0, irq}, 32'h0);
        busOp(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
        check("irq_status", q, 32'h3);
        wr(`OFS_IRQ_ENABLE, 32'h2);
        @(posedge clock);
        check("irq_raised", {31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_CLEAR, 32'h2);
        @(posedge clock);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        busOp(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
        check("irq_status_left", q, 32'h1);
        // A second reset in mid-run must bring hreadyout, mValid, linkReqOut, irq, the interrupt status and the control register back to their reset values.
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        check("hreadyout_reset", {31'h0, hreadyout}, 32'h0);
        check("mvalid_reset", {31'h0, mValid}, 32'h0);
        check("link_reset", {28'h0, linkReqOut}, 32'h0);
        check("irq_in_reset", {31'h0, irq}, 32'h0);
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        busOp(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
        check("irq_status_reset", q, 32'h0);
        busOp(1'b0, `OFS_CHANNEL_CONTROL, 32'h0, q);
        check("control_after_reset", q, `CTRL_RESET);
        check("hresp", {31'h0, hresp}, 32'h0);
        conclude();
    end
endmodule
